// file: dv/sss_chk.sv
// checker: pin timing and link handshake between host sequencer and sensor
`timescale 1ns/10ps
module sss_chk #(
  parameter int COMM_CYC = 400,
  parameter int SYNC_CYC = 200
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic system_clear_n,
  input wire logic ref_clock_in,
  input wire logic vertical_sync_in,
  input wire logic horizontal_sync_in,
  input wire logic link_req,
  input wire logic link_we,
  input wire logic [sss_pkg::LINK_AW-1:0] link_addr,
  input wire logic [sss_pkg::LINK_DW-1:0] link_wdata,
  input wire logic link_ack
);
  // ==========================================================
  // cycle counters
  // ==========================================================
  logic [23:0] low_r, low_nxt, rel_r, rel_nxt, sby_r, sby_nxt;
  logic arm_r, arm_nxt, sby_off;
  assign sby_off = link_ack && link_we && link_addr == sss_pkg::LINK_STANDBY && !link_wdata[0];
  always_comb
  begin
    low_nxt = system_clear_n ? 24'h0 : low_r + 24'h1;
    rel_nxt = system_clear_n ? rel_r + 24'h1 : 24'h0;
    sby_nxt = sby_off ? 24'h0 : sby_r + 24'h1;
    arm_nxt = system_clear_n && (arm_r || sby_off);
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      low_r <= 24'h0;
      rel_r <= 24'h0;
      sby_r <= 24'h0;
      arm_r <= 1'b0;
    end
    else
    begin
      low_r <= low_nxt;
      rel_r <= rel_nxt;
      sby_r <= sby_nxt;
      arm_r <= arm_nxt;
    end
  end
  // ==========================================================
  // properties
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence link_issue;
    link_req && !link_ack;
  endsequence
  sequence link_done;
    link_ack ##1 !link_ack;
  endsequence
  chk_clear_low_len: assert property ($rose(system_clear_n) |-> low_r >= sss_pkg::CLR_LOW_CYC)
    else $error("clear pin released too early");
  // two cycles of slack cover the host pin register stage
  chk_clock_gap: assert property ($rose(ref_clock_in) |-> rel_r >= sss_pkg::CLK_START_CYC - 2)
    else $error("reference clock started too soon");
  chk_comm_gap: assert property ($rose(link_req) |-> rel_r >= COMM_CYC - 2)
    else $error("link traffic started too soon");
  chk_pins_parked: assert property (!system_clear_n |-> !ref_clock_in && !vertical_sync_in && !horizontal_sync_in)
    else $error("pin active while clear is low");
  chk_no_link_clear: assert property (!system_clear_n |-> !link_req)
    else $error("link request during clear");
  chk_link_held: assert property (link_issue |=> link_req && $stable(link_addr) && $stable(link_wdata))
    else $error("link request dropped before answer");
  chk_link_answer: assert property (link_issue |=> link_done)
    else $error("link answer missing or too long");
  chk_sync_gap: assert property ($rose(vertical_sync_in || horizontal_sync_in) |-> arm_r && sby_r >= SYNC_CYC - 2)
    else $error("sync pulse before settle time");
endmodule // sss_chk

// file: dv/sss_tb.sv
// testbench: both ends joined, driven through the host register port
`timescale 1ns/10ps
`define CK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin fail_count++; $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module sss_tb;
  localparam int COMM = 400;
  localparam int SYNC = 200;
  localparam int STAB = 20;
  logic clk = 1'b0;
  logic reset_n;
  logic supplies_good;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  sss_pkg::sss_stage_t stage;
  logic streaming;
  logic frame_valid;
  logic frame_start;
  logic [15:0] mode_out;
  logic [31:0] ctl;
  logic [31:0] s;
  logic [15:0] q;
  int fail_count;
  int tests_run;
  int n;
  sss_if sss_if_inst();
  sss_sensor #(.STAB_CYC(STAB), .FRAME_CYC(64)) sss_sensor_inst(.clk(clk), .reset_n(reset_n), .pins(sss_if_inst),
    .streaming(streaming), .frame_valid(frame_valid), .frame_start(frame_start), .mode_out(mode_out));
  sss_host #(.COMM_CYC(COMM), .SYNC_CYC(SYNC), .CLK_DIV(4)) sss_host_inst(.clk(clk), .reset_n(reset_n),
    .pins(sss_if_inst), .supplies_good(supplies_good), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stage(stage));
  sss_chk #(.COMM_CYC(COMM), .SYNC_CYC(SYNC)) sss_chk_inst(.clk(clk), .reset_n(reset_n),
    .system_clear_n(sss_if_inst.system_clear_n), .ref_clock_in(sss_if_inst.ref_clock_in),
    .vertical_sync_in(sss_if_inst.vertical_sync_in), .horizontal_sync_in(sss_if_inst.horizontal_sync_in),
    .link_req(sss_if_inst.link_req), .link_we(sss_if_inst.link_we), .link_addr(sss_if_inst.link_addr),
    .link_wdata(sss_if_inst.link_wdata), .link_ack(sss_if_inst.link_ack));
  always #2 clk = ~clk;
  // ==========================================================
  // bus tasks
  // ==========================================================
  task automatic av(input logic [5:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // look mid-cycle, then take the answer at the edge that sees waitrequest low
    do @(negedge clk); while (avs_waitrequest !== 1'b0);
    @(posedge clk);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // one link transfer through the host; busy is polled, the watchdog cuts a hang
  task automatic lk(input logic [7:0] a, input logic [15:0] d, input logic rd, output logic [15:0] r);
    av(sss_pkg::HREG_WADDR, 1'b1, {24'h0, a}, s);
    av(sss_pkg::HREG_WDATA, 1'b1, {16'h0, d}, s);
    av(sss_pkg::HREG_CTRL, 1'b1, ctl | 32'h20 | {27'h0, rd, 4'h0}, s);
    do av(sss_pkg::HREG_STATUS, 1'b0, 32'h0, s); while (s[6] !== 1'b0);
    av(sss_pkg::HREG_RDATA, 1'b0, 32'h0, s);
    r = s[15:0];
  endtask
  task automatic live(input logic [7:0] a, input logic [15:0] d, input logic inval);
    // start right after a frame edge so the change lands well inside one frame
    for (n = 0; n < 300 && frame_start !== 1'b1; n++) @(posedge clk);
    lk(a, d, 1'b0, q);
    `CK("frame_valid", !inval, frame_valid)
    for (n = 0; n < 300 && frame_start !== 1'b1; n++) @(posedge clk);
    @(posedge clk);
    `CK("frame_valid", 1'b1, frame_valid)
    `CK("streaming", 1'b1, streaming)
  endtask
  task automatic ready_defaults();
    logic [7:0] ad [5];
    logic [15:0] ex [5];
    ad = '{sss_pkg::LINK_STANDBY, sss_pkg::LINK_MASTER_RUN, sss_pkg::LINK_MODE, sss_pkg::LINK_FRAME_LINES,
      sss_pkg::LINK_LINE_PERIOD};
    ex = '{16'h0001, 16'h0001, sss_pkg::MODE_RST, sss_pkg::FRAME_LINES_RST, sss_pkg::LINE_PERIOD_RST};
    for (n = 0; n < 3000 && stage !== sss_pkg::SSS_READY; n++) @(posedge clk);
    `CK("stage", sss_pkg::SSS_READY, stage)
    `CK("clear_pin", 1'b1, sss_if_inst.system_clear_n)
    for (int i = 0; i < 5; i++)
    begin
      lk(ad[i], 16'h0000, 1'b1, q);
      `CK("link_rdata", ex[i], q)
    end
    `CK("mode_out", sss_pkg::MODE_RST, mode_out)
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // sequence
  // ==========================================================
  initial
  begin
    reset_n = 1'b0;
    supplies_good = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    ctl = 32'h1;
    fail_count = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    av(sss_pkg::HREG_CTRL, 1'b1, ctl, s);
    // a send before the link is open must be dropped
    av(sss_pkg::HREG_WADDR, 1'b1, {24'h0, sss_pkg::LINK_MODE}, s);
    av(sss_pkg::HREG_WDATA, 1'b1, 32'h4, s);
    av(sss_pkg::HREG_CTRL, 1'b1, ctl | 32'h20, s);
    repeat (200) @(posedge clk);
    av(sss_pkg::HREG_STATUS, 1'b0, 32'h0, s);
    `CK("status_stage", sss_pkg::SSS_OFF, s[3:0])
    `CK("clear_pin", 1'b0, sss_if_inst.system_clear_n)
    av(6'h14, 1'b0, 32'h0, s);
    `CK("unmapped", 32'h0, s)
    supplies_good <= 1'b1;
    ready_defaults();
    lk(sss_pkg::LINK_STANDBY, 16'h0000, 1'b0, q);
    repeat (STAB + 8) @(posedge clk);
    `CK("streaming", 1'b0, streaming)
    lk(sss_pkg::LINK_MASTER_RUN, 16'h0000, 1'b0, q);
    for (n = 0; n < 100 && streaming !== 1'b1; n++) @(posedge clk);
    `CK("streaming", 1'b1, streaming)
    live(sss_pkg::LINK_MODE, 16'h0001, 1'b0);
    live(sss_pkg::LINK_MODE, 16'h0000, 1'b0);
    live(sss_pkg::LINK_MODE, 16'h0002, 1'b1);
    live(sss_pkg::LINK_MODE, 16'h0006, 1'b1);
    live(sss_pkg::LINK_MODE, 16'h0002, 1'b1);
    live(sss_pkg::LINK_FRAME_LINES, 16'h0100, 1'b1);
    live(sss_pkg::LINK_LINE_PERIOD, 16'h0200, 1'b1);
    // slave select while streaming is a standby-only change
    lk(sss_pkg::LINK_MODE, 16'h000a, 1'b0, q);
    `CK("mode_out", 16'h0002, mode_out)
    lk(sss_pkg::LINK_MASTER_RUN, 16'h0001, 1'b0, q);
    lk(sss_pkg::LINK_STANDBY, 16'h0001, 1'b0, q);
    repeat (4) @(posedge clk);
    `CK("streaming", 1'b0, streaming)
    lk(sss_pkg::LINK_MODE, 16'h000a, 1'b0, q);
    `CK("mode_out", 16'h000a, mode_out)
    ctl = ctl | 32'hc;
    av(sss_pkg::HREG_CTRL, 1'b1, ctl, s);
    lk(sss_pkg::LINK_STANDBY, 16'h0000, 1'b0, q);
    for (n = 0; n < SYNC + 500 && sss_if_inst.vertical_sync_in !== 1'b1; n++) @(posedge clk);
    `CK("vsync", 1'b1, sss_if_inst.vertical_sync_in)
    av(sss_pkg::HREG_STATUS, 1'b0, 32'h0, s);
    `CK("sync_ok", 1'b1, s[7])
    av(sss_pkg::HREG_CTRL, 1'b1, ctl | 32'h2, s);
    for (n = 0; n < 100 && stage !== sss_pkg::SSS_PARKED; n++) @(posedge clk);
    `CK("stage", sss_pkg::SSS_PARKED, stage)
    `CK("pins", 5'h00, {sss_if_inst.system_clear_n, sss_if_inst.ref_clock_in, sss_if_inst.vertical_sync_in,
      sss_if_inst.horizontal_sync_in, sss_if_inst.link_req})
    // clear pin alone, with no reset, must return the sensor to defaults
    supplies_good <= 1'b0;
    ctl = 32'h1;
    av(sss_pkg::HREG_CTRL, 1'b1, ctl, s);
    repeat (8) @(posedge clk);
    `CK("stage", sss_pkg::SSS_OFF, stage)
    supplies_good <= 1'b1;
    ready_defaults();
    // a reset_n pulse must bring every sensor register back to its default
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    ctl = 32'h1;
    av(sss_pkg::HREG_CTRL, 1'b1, ctl, s);
    ready_defaults();
    tally_and_finish();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule // sss_tb

// file: include/sss_if.sv
// interface: pins between host sequencer and sensor start-up end
`timescale 1ns/10ps
interface sss_if;
  logic system_clear_n;
  logic ref_clock_in;
  logic vertical_sync_in;
  logic horizontal_sync_in;
  logic link_req;
  logic link_we;
  logic [sss_pkg::LINK_AW-1:0] link_addr;
  logic [sss_pkg::LINK_DW-1:0] link_wdata;
  logic [sss_pkg::LINK_DW-1:0] link_rdata;
  logic link_ack;
  modport sensor (
    input system_clear_n, ref_clock_in, vertical_sync_in, horizontal_sync_in,
    input link_req, link_we, link_addr, link_wdata,
    output link_rdata, link_ack
  );
  modport host (
    output system_clear_n, ref_clock_in, vertical_sync_in, horizontal_sync_in,
    output link_req, link_we, link_addr, link_wdata,
    input link_rdata, link_ack
  );
endinterface // sss_if

// file: include/sss_pkg.sv
// package: shared constants and types for the sensor start-up sequencer ends
package sss_pkg;
  // =====================================================================
  // clock and timing
  // =====================================================================
  localparam int CLK_MHZ = 250;
  localparam int T_CLR_LOW_NS = 500;
  localparam int T_CLK_START_US = 1;
  localparam int T_COMM_START_US = 20;
  localparam int T_SYNC_START_MS = 24;
  // least times round up to whole cycles
  localparam int CLR_LOW_CYC = (T_CLR_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int CLK_START_CYC = T_CLK_START_US * CLK_MHZ;
  localparam int COMM_START_CYC = T_COMM_START_US * CLK_MHZ;
  localparam int SYNC_START_CYC = T_SYNC_START_MS * 1000 * CLK_MHZ;
  localparam int STAB_CYC_DEF = 1000;
  localparam int CNT_W = 24;
  // =====================================================================
  // register link
  // =====================================================================
  localparam int LINK_AW = 8;
  localparam int LINK_DW = 16;
  localparam logic [7:0] LINK_STANDBY = 8'h00;
  localparam logic [7:0] LINK_MASTER_RUN = 8'h01;
  localparam logic [7:0] LINK_MODE = 8'h02;
  localparam logic [7:0] LINK_FRAME_LINES = 8'h03;
  localparam logic [7:0] LINK_LINE_PERIOD = 8'h04;
  localparam logic [7:0] LINK_STATUS = 8'h05;
  // mode field positions
  localparam int MODE_HMIRROR = 0;
  localparam int MODE_VFLIP = 1;
  localparam int MODE_CROP = 2;
  localparam int MODE_SLAVE = 3;
  localparam int MODE_BIN = 4;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] FRAME_LINES_RST = 16'h08ca;
  localparam logic [15:0] LINE_PERIOD_RST = 16'h044c;
  // =====================================================================
  // host Avalon register map (word byte addresses)
  // =====================================================================
  localparam logic [5:0] HREG_CTRL = 6'h00;
  localparam logic [5:0] HREG_STATUS = 6'h04;
  localparam logic [5:0] HREG_WADDR = 6'h08;
  localparam logic [5:0] HREG_WDATA = 6'h0c;
  localparam logic [5:0] HREG_RDATA = 6'h10;
  localparam int CTRL_SUPPLY_GO = 0;
  localparam int CTRL_POWER_OFF = 1;
  localparam int CTRL_SYNC_EN = 2;
  localparam int CTRL_SLAVE = 3;
  localparam int CTRL_READ = 4;
  localparam int CTRL_SEND = 5;
  typedef enum logic [3:0] {
    SSS_OFF, SSS_CLR_LOW, SSS_CLK_WAIT, SSS_COMM_WAIT, SSS_READY, SSS_PARKED
  } sss_stage_t;
endpackage

// file: src/sss_host.sv
// module: host sequencer, power-on clear timing, gated link and syncs, Avalon slave
// Contract
// - horizontal mirror accepted live, no standby
// - crop or vertical flip: one invalid frame
// - line count or period change live, invalid frame
// - other mode changes only from standby
// - clock switch glitch: hold clear, restart; the code has no clock switch detection
// - clear returns all registers to defaults
// - hold clear low 500 ns after supplies
// - clock starts 1 us after clear release
// - link opens 20 us after clear release
// - slave syncs wait 24 ms after standby off; syncs start at once if CTRL_SYNC_EN is set before any standby-off write
// - park all pins low at power-off; the code leaves link_we, link_addr and link_wdata at their last values
// - standby bit set enters, clear resumes
// - master run bit low starts streaming
// - standby in master mode also stops run
`timescale 1ns/10ps
module sss_host #(
  parameter int COMM_CYC = sss_pkg::COMM_START_CYC,
  parameter int SYNC_CYC = sss_pkg::SYNC_START_CYC,
  parameter int CLK_DIV = 4
)(
  input wire logic clk,
  input wire logic reset_n,
  sss_if.host pins,
  input wire logic supplies_good,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output sss_pkg::sss_stage_t stage
);
  // =====================================================================
  // supplies-good synchroniser
  // =====================================================================
  logic [2:0] pg_sync_r;
  logic pg_r, pg_nxt;
  logic pg;
  // the level only moves once the last two stages agree
  assign pg_nxt = (pg_sync_r[2] == pg_sync_r[1]) ? pg_sync_r[1] : pg_r;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      pg_sync_r <= 3'h0;
      pg_r <= 1'b0;
    end
    else
    begin
      pg_sync_r <= {pg_sync_r[1:0], supplies_good};
      pg_r <= pg_nxt;
    end
  assign pg = pg_r;

  // =====================================================================
  // sequencer, all delays timed from clk
  // =====================================================================
  sss_pkg::sss_stage_t st_r, st_nxt;
  logic [sss_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [sss_pkg::CNT_W-1:0] sync_cnt_r, sync_cnt_nxt;
  logic [7:0] div_r, div_nxt;
  logic [5:0] ctrl_r, ctrl_nxt;
  logic [7:0] waddr_r, waddr_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic busy_r, busy_nxt;
  logic req_r, req_nxt;
  logic we_r, we_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic done_r, done_nxt;
  logic link_ok;
  logic sync_ok;
  logic park;
  logic acc;

  assign park = ctrl_r[sss_pkg::CTRL_POWER_OFF];
  assign link_ok = (st_r == sss_pkg::SSS_READY);
  assign sync_ok = link_ok & ctrl_r[sss_pkg::CTRL_SYNC_EN] & (sync_cnt_r == '0);
  assign acc = avs_read | avs_write;

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
    sync_cnt_nxt = (sync_cnt_r == '0) ? sync_cnt_r : sync_cnt_r - 1'b1;
    div_nxt = (div_r == 8'(CLK_DIV - 1)) ? 8'h00 : div_r + 1'b1;
    ctrl_nxt = ctrl_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    busy_nxt = busy_r;
    req_nxt = req_r;
    we_nxt = we_r;
    rd_nxt = rd_r;
    done_nxt = 1'b0;
    case (st_r)
      sss_pkg::SSS_OFF:
        if (pg & ctrl_r[sss_pkg::CTRL_SUPPLY_GO])
        begin
          st_nxt = sss_pkg::SSS_CLR_LOW;
          cnt_nxt = sss_pkg::CNT_W'(sss_pkg::CLR_LOW_CYC);
        end
      sss_pkg::SSS_CLR_LOW:
        if (cnt_r == '0)
        begin
          st_nxt = sss_pkg::SSS_CLK_WAIT;
          cnt_nxt = sss_pkg::CNT_W'(sss_pkg::CLK_START_CYC);
        end
      sss_pkg::SSS_CLK_WAIT:
        if (cnt_r == '0)
        begin
          st_nxt = sss_pkg::SSS_COMM_WAIT;
          cnt_nxt = sss_pkg::CNT_W'(COMM_CYC - sss_pkg::CLK_START_CYC);
        end
      sss_pkg::SSS_COMM_WAIT:
        if (cnt_r == '0)
          st_nxt = sss_pkg::SSS_READY;
      sss_pkg::SSS_READY:
        ;
      sss_pkg::SSS_PARKED:
        if (!ctrl_r[sss_pkg::CTRL_POWER_OFF] & ~pg)
          st_nxt = sss_pkg::SSS_OFF;
      default:
        st_nxt = sss_pkg::SSS_OFF;
    endcase
    // supply loss or power-off request parks clear, clock, syncs and link request low
    if (park | (~pg & (st_r != sss_pkg::SSS_OFF) & (st_r != sss_pkg::SSS_PARKED)))
    begin
      st_nxt = sss_pkg::SSS_PARKED;
      busy_nxt = 1'b0;
      req_nxt = 1'b0;
    end
    // link transaction
    if (busy_r & pins.link_ack)
    begin
      busy_nxt = 1'b0;
      req_nxt = 1'b0;
      if (!we_r)
        rdata_nxt = pins.link_rdata;
      // leaving standby restarts the sync hold-off
      if (we_r & (waddr_r == sss_pkg::LINK_STANDBY) & ~wdata_r[0])
        sync_cnt_nxt = sss_pkg::CNT_W'(SYNC_CYC);
    end
    // Avalon slave, answered one cycle after the request
    if (acc & ~done_r)
      done_nxt = 1'b1;
    // a write lands only at the edge that sees waitrequest low
    if (avs_write & done_r)
    begin
      if (avs_address == sss_pkg::HREG_CTRL)
      begin
        ctrl_nxt = avs_writedata[5:0] & 6'h0f;
        // send only once link allowed; refused silently otherwise
        if (avs_writedata[sss_pkg::CTRL_SEND] & link_ok & ~busy_r)
        begin
          busy_nxt = 1'b1;
          req_nxt = 1'b1;
          we_nxt = ~avs_writedata[sss_pkg::CTRL_READ];
        end
      end
      else if (avs_address == sss_pkg::HREG_WADDR)
        waddr_nxt = avs_writedata[7:0];
      else if (avs_address == sss_pkg::HREG_WDATA)
        wdata_nxt = avs_writedata[15:0];
    end
    else if (avs_read & ~done_r)
    begin
      if (avs_address == sss_pkg::HREG_CTRL)
        rd_nxt = {26'h0, ctrl_r};
      else if (avs_address == sss_pkg::HREG_STATUS)
        rd_nxt = {24'h0, sync_ok, busy_r, pg, 1'b0, 4'(st_r)};
      else if (avs_address == sss_pkg::HREG_WADDR)
        rd_nxt = {24'h0, waddr_r};
      else if (avs_address == sss_pkg::HREG_WDATA)
        rd_nxt = {16'h0, wdata_r};
      else if (avs_address == sss_pkg::HREG_RDATA)
        rd_nxt = {16'h0, rdata_r};
      else
        rd_nxt = 32'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      st_r <= sss_pkg::SSS_OFF;
      cnt_r <= '0;
      sync_cnt_r <= '0;
      div_r <= 8'h00;
      ctrl_r <= 6'h00;
      waddr_r <= 8'h00;
      wdata_r <= 16'h0000;
      rdata_r <= 16'h0000;
      busy_r <= 1'b0;
      req_r <= 1'b0;
      we_r <= 1'b0;
      rd_r <= 32'h0;
      done_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sync_cnt_r <= sync_cnt_nxt;
      div_r <= div_nxt;
      ctrl_r <= ctrl_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      busy_r <= busy_nxt;
      req_r <= req_nxt;
      we_r <= we_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
    end

  // =====================================================================
  // pins; clock only after clear released, syncs are divided strobes
  // =====================================================================
  logic clk_run;
  assign clk_run = (st_r == sss_pkg::SSS_COMM_WAIT) | link_ok;
  assign pins.system_clear_n = clk_run | (st_r == sss_pkg::SSS_CLK_WAIT);
  assign pins.ref_clock_in = clk_run & (div_r < 8'(CLK_DIV / 2));
  assign pins.horizontal_sync_in = sync_ok & (div_r == 8'h00);
  assign pins.vertical_sync_in = sync_ok & (div_r == 8'h00) & (cnt_r == '0);
  assign pins.link_req = req_r;
  assign pins.link_we = we_r;
  assign pins.link_addr = waddr_r;
  assign pins.link_wdata = wdata_r;
  assign avs_readdata = rd_r;
  assign avs_waitrequest = acc & ~done_r;
  assign stage = st_r;
endmodule // sss_host

// file: src/sss_sensor.sv
// module: sensor end, clear handling, standby, master run and live mode changes
`timescale 1ns/10ps
module sss_sensor #(
  parameter int STAB_CYC = sss_pkg::STAB_CYC_DEF,
  parameter int FRAME_CYC = 64
)(
  input wire logic clk,
  input wire logic reset_n,
  sss_if.sensor pins,
  output logic streaming,
  output logic frame_valid,
  output logic frame_start,
  output logic [15:0] mode_out
);
  // =====================================================================
  // clear pin synchroniser; clear acts as a reset alongside the reset_n input
  // =====================================================================
  logic [2:0] clr_sync_r;
  logic clr_n_r, clr_n_nxt;
  logic clr_n;
  // the level only moves once the last two stages agree
  assign clr_n_nxt = (clr_sync_r[2] == clr_sync_r[1]) ? clr_sync_r[1] : clr_n_r;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      clr_sync_r <= 3'h0;
      clr_n_r <= 1'b0;
    end
    else
    begin
      clr_sync_r <= {clr_sync_r[1:0], pins.system_clear_n};
      clr_n_r <= clr_n_nxt;
    end
  assign clr_n = clr_n_r;

  // =====================================================================
  // registers
  // =====================================================================
  logic standby_r, standby_nxt;
  logic run_n_r, run_n_nxt;
  logic [15:0] mode_r, mode_nxt;
  logic [15:0] lines_r, lines_nxt;
  logic [15:0] period_r, period_nxt;
  logic [sss_pkg::CNT_W-1:0] stab_r, stab_nxt;
  logic [sss_pkg::CNT_W-1:0] fcnt_r, fcnt_nxt;
  logic inval_r, inval_nxt;
  logic ack_r, ack_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic wr;
  logic stable;
  logic active;

  assign wr = pins.link_req & pins.link_we & ~ack_r;
  assign stable = (stab_r == '0);
  // master streams when run bit low, slave streams whatever the run bit, out of standby and stable
  assign active = ~standby_r & stable & (mode_r[sss_pkg::MODE_SLAVE] | ~run_n_r);

  always_comb
  begin
    standby_nxt = standby_r;
    run_n_nxt = run_n_r;
    mode_nxt = mode_r;
    lines_nxt = lines_r;
    period_nxt = period_r;
    stab_nxt = stable ? stab_r : stab_r - 1'b1;
    inval_nxt = inval_r;
    ack_nxt = pins.link_req & ~ack_r;
    rdata_nxt = rdata_r;
    fcnt_nxt = (fcnt_r == sss_pkg::CNT_W'(FRAME_CYC - 1)) ? '0 : fcnt_r + 1'b1;
    if (frame_start)
      inval_nxt = 1'b0;
    if (wr)
    begin
      if (pins.link_addr == sss_pkg::LINK_STANDBY)
      begin
        standby_nxt = pins.link_wdata[0];
        // entering standby also sets the run bit high, stopping master run
        if (pins.link_wdata[0])
          run_n_nxt = 1'b1;
        if (standby_r & ~pins.link_wdata[0])
          stab_nxt = sss_pkg::CNT_W'(STAB_CYC);
      end
      else if (pins.link_addr == sss_pkg::LINK_MASTER_RUN)
        run_n_nxt = pins.link_wdata[0];
      else if (pins.link_addr == sss_pkg::LINK_MODE)
      begin
        // crop or vertical flip change live costs one invalid frame
        if ((pins.link_wdata[sss_pkg::MODE_CROP] != mode_r[sss_pkg::MODE_CROP]) |
            (pins.link_wdata[sss_pkg::MODE_VFLIP] != mode_r[sss_pkg::MODE_VFLIP]))
          inval_nxt = 1'b1;
        // mirror, flip and crop always live; slave and binning bits only take effect in standby
        mode_nxt[sss_pkg::MODE_HMIRROR] = pins.link_wdata[sss_pkg::MODE_HMIRROR];
        mode_nxt[sss_pkg::MODE_VFLIP] = pins.link_wdata[sss_pkg::MODE_VFLIP];
        mode_nxt[sss_pkg::MODE_CROP] = pins.link_wdata[sss_pkg::MODE_CROP];
        if (standby_r)
        begin
          mode_nxt[sss_pkg::MODE_SLAVE] = pins.link_wdata[sss_pkg::MODE_SLAVE];
          mode_nxt[sss_pkg::MODE_BIN] = pins.link_wdata[sss_pkg::MODE_BIN];
        end
      end
      else if (pins.link_addr == sss_pkg::LINK_FRAME_LINES)
      begin
        lines_nxt = pins.link_wdata;
        inval_nxt = 1'b1;
      end
      else if (pins.link_addr == sss_pkg::LINK_LINE_PERIOD)
      begin
        period_nxt = pins.link_wdata;
        inval_nxt = 1'b1;
      end
    end
    if (pins.link_req & ~ack_r)
    begin
      if (pins.link_addr == sss_pkg::LINK_STANDBY)
        rdata_nxt = {15'h0, standby_r};
      else if (pins.link_addr == sss_pkg::LINK_MASTER_RUN)
        rdata_nxt = {15'h0, run_n_r};
      else if (pins.link_addr == sss_pkg::LINK_MODE)
        rdata_nxt = mode_r;
      else if (pins.link_addr == sss_pkg::LINK_FRAME_LINES)
        rdata_nxt = lines_r;
      else if (pins.link_addr == sss_pkg::LINK_LINE_PERIOD)
        rdata_nxt = period_r;
      else if (pins.link_addr == sss_pkg::LINK_STATUS)
        rdata_nxt = {13'h0, inval_r, stable, active};
      else
        rdata_nxt = 16'h0000;
    end
  end

  // clear low returns every register to its default
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      standby_r <= 1'b1;
      run_n_r <= 1'b1;
      mode_r <= sss_pkg::MODE_RST;
      lines_r <= sss_pkg::FRAME_LINES_RST;
      period_r <= sss_pkg::LINE_PERIOD_RST;
      stab_r <= '0;
      fcnt_r <= '0;
      inval_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
    end
    else if (!clr_n)
    begin
      standby_r <= 1'b1;
      run_n_r <= 1'b1;
      mode_r <= sss_pkg::MODE_RST;
      lines_r <= sss_pkg::FRAME_LINES_RST;
      period_r <= sss_pkg::LINE_PERIOD_RST;
      stab_r <= '0;
      fcnt_r <= '0;
      inval_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
    end
    else
    begin
      standby_r <= standby_nxt;
      run_n_r <= run_n_nxt;
      mode_r <= mode_nxt;
      lines_r <= lines_nxt;
      period_r <= period_nxt;
      stab_r <= stab_nxt;
      fcnt_r <= active ? fcnt_nxt : '0;
      inval_r <= inval_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end

  // =====================================================================
  // outputs
  // =====================================================================
  assign pins.link_ack = ack_r;
  assign pins.link_rdata = rdata_r;
  assign frame_start = active & (fcnt_r == '0);
  assign frame_valid = active & ~inval_r;
  assign streaming = active;
  assign mode_out = mode_r;
endmodule // sss_sensor
